// [src/scpc_cfg.svh]
/*
 * Named offsets, field positions, reset values and wait times of the second
 * synthesizer calibration and program-cycle counter register bank.
 * Assumes a 250 MHz always-on clock; every time is kept in its printed unit.
 */
`ifndef SCPC_CFG_SVH
`define SCPC_CFG_SVH

`define SCPC_ADDR_CAL_WAIT   8'h85
`define SCPC_ADDR_LOOP_BW    8'h86
`define SCPC_ADDR_PROG_CNT   8'h88

`define SCPC_CLSD_HI         3
`define SCPC_CLSD_LO         2
`define SCPC_VCO_HI          1
`define SCPC_VCO_LO          0
`define SCPC_BW_BIT          0

`define SCPC_CLSD_RST        2'h0
`define SCPC_VCO_RST         2'h1
`define SCPC_BW_RST          1'h0
`define SCPC_CNT_RST         8'h00
`define SCPC_CNT_MAX         8'hFF
`define SCPC_RD_ZERO         8'h00

`define SCPC_CLK_MHZ         250
`define SCPC_US_PER_MS       1000
`define SCPC_CLSD0_US        30
`define SCPC_CLSD1_US        300
`define SCPC_CLSD2_MS        30
`define SCPC_CLSD3_MS        300
`define SCPC_VCO0_US         20
`define SCPC_VCO1_US         400
`define SCPC_VCO2_MS         8
`define SCPC_VCO3_MS         200
`define SCPC_PROG_MS         230

`endif

// [src/scpc_pkg.sv]
/*
 * Types shared by the calibration wait and program-cycle counter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scpc_pkg;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_VCO,
        CAL_CLSD
    } scpc_cal_state_t;

    typedef enum logic [1:0] {
        NVM_IDLE,
        NVM_LOAD,
        NVM_PROG
    } scpc_nvm_state_t;

endpackage : scpc_pkg

// [src/scpc_top.sv]
/*
 * Register bank for the second synthesizer's calibration waits and loop
 * bandwidth, with the saturating nonvolatile program-cycle counter.
 * Assumes the serial configuration logic and memory controller share i_clk.
 */
`timescale 1ns/1ps
`include "scpc_cfg.svh"

// Contract
// [R1] Closed-loop code selects 30us/300us/30ms/300ms wait.
// [R2] Software uses closed-loop code 1 above 10kHz.
// [R3] Closed-loop code bits 3:2, RW, resets 0.
// [R4] VCO code selects 20us/400us/8ms/200ms; resets 1.
// [R5] Software keeps VCO code at 1.
// [R6] Bandwidth bit high selects 200 Hz mode.
// [R7] Counter increments after each completed program cycle.
// [R8] Count is stored in nonvolatile memory.
// [R9] Count reloads after reset, commit, program.
// [R10] Count saturates at 255.
// [R11] Count read-only, reads zero until loaded.
// [R12] Program cycle lasts about 230 ms.
// [R13] Commit bit loads registers, self-clears when done.
// [R14] VCO wait first, then closed-loop wait.
module scpc_top
    import scpc_pkg::*;
#(
    parameter int unsigned TMR_W     = 27,
    parameter int unsigned CLSD0_CYC = `SCPC_CLSD0_US * `SCPC_CLK_MHZ,
    parameter int unsigned CLSD1_CYC = `SCPC_CLSD1_US * `SCPC_CLK_MHZ,
    parameter int unsigned CLSD2_CYC = `SCPC_CLSD2_MS * `SCPC_US_PER_MS * `SCPC_CLK_MHZ,
    parameter int unsigned CLSD3_CYC = `SCPC_CLSD3_MS * `SCPC_US_PER_MS * `SCPC_CLK_MHZ,
    parameter int unsigned VCO0_CYC  = `SCPC_VCO0_US * `SCPC_CLK_MHZ,
    parameter int unsigned VCO1_CYC  = `SCPC_VCO1_US * `SCPC_CLK_MHZ,
    parameter int unsigned VCO2_CYC  = `SCPC_VCO2_MS * `SCPC_US_PER_MS * `SCPC_CLK_MHZ,
    parameter int unsigned VCO3_CYC  = `SCPC_VCO3_MS * `SCPC_US_PER_MS * `SCPC_CLK_MHZ,
    parameter int unsigned PROG_CYC  = `SCPC_PROG_MS * `SCPC_US_PER_MS * `SCPC_CLK_MHZ
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_cal_start,
    output logic            o_cal_busy,
    output logic            o_cal_done,
    output logic            o_narrow_bw,
    input  wire logic       i_commit_req,
    output logic            o_commit_pending,
    input  wire logic       i_prog_start,
    output logic            o_nvm_busy,
    output logic            o_nvm_load_req,
    input  wire logic       i_nvm_load_valid,
    input  wire logic [7:0] i_nvm_load_cal_wait,
    input  wire logic [7:0] i_nvm_load_loop_bw,
    input  wire logic [7:0] i_nvm_load_count,
    output logic            o_nvm_count_store,
    output logic      [7:0] o_nvm_count_store_data
);

    function automatic logic [TMR_W-1:0] pick_wait(input logic [1:0] code,
                                                  input int unsigned c0,
                                                  input int unsigned c1,
                                                  input int unsigned c2,
                                                  input int unsigned c3);
        logic [TMR_W-1:0] res;
        case (code)
            2'h0:    res = TMR_W'(c0);
            2'h1:    res = TMR_W'(c1);
            2'h2:    res = TMR_W'(c2);
            default: res = TMR_W'(c3);
        endcase
        return res;
    endfunction : pick_wait

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == `SCPC_CNT_MAX) ? v : v + 8'h01; // [R10]
    endfunction : sat_inc

    // Register file and read path.
    logic [1:0] clsd_code_q, clsd_code_d;
    logic [1:0] vco_code_q,  vco_code_d;
    logic       bw_q,        bw_d;
    logic [7:0] prog_count_q, prog_count_d;
    logic [7:0] rdata_q,     rdata_d;

    // Memory sequencing.
    scpc_nvm_state_t nvm_q, nvm_d;
    logic       boot_q,   boot_d;
    logic       commit_q, commit_d;
    logic       load_req_q, load_req_d;
    logic       store_q,  store_d;
    logic [7:0] store_data_q, store_data_d;
    logic       prog_tmr_start;
    logic       prog_tmr_done;

    // Calibration sequencing.
    scpc_cal_state_t cal_q, cal_d;
    logic [TMR_W-1:0] vco_len_q, vco_len_d;
    logic [TMR_W-1:0] clsd_len_q, clsd_len_d;
    logic             cal_done_q, cal_done_d;
    logic             cal_tmr_start;
    logic [TMR_W-1:0] cal_tmr_cycles;
    logic             cal_tmr_done;

    logic load_now;
    assign load_now = (nvm_q == NVM_LOAD) && i_nvm_load_valid;

    always_comb begin
        clsd_code_d  = clsd_code_q;
        vco_code_d   = vco_code_q;
        bw_d         = bw_q;
        prog_count_d = prog_count_q;
        rdata_d      = rdata_q;
        if (i_reg_wr && i_reg_addr == `SCPC_ADDR_CAL_WAIT) begin
            clsd_code_d = i_reg_wdata[`SCPC_CLSD_HI:`SCPC_CLSD_LO]; // [R3]
            vco_code_d  = i_reg_wdata[`SCPC_VCO_HI:`SCPC_VCO_LO];
        end
        if (i_reg_wr && i_reg_addr == `SCPC_ADDR_LOOP_BW) begin
            bw_d = i_reg_wdata[`SCPC_BW_BIT];
        end
        // Writes to the count address fall through: the field is read-only. [R11]
        // A memory transfer overrides a write landing in the same cycle, since
        // the stored image is what the device must come up with.
        if (load_now) begin
            clsd_code_d  = i_nvm_load_cal_wait[`SCPC_CLSD_HI:`SCPC_CLSD_LO]; // [R13]
            vco_code_d   = i_nvm_load_cal_wait[`SCPC_VCO_HI:`SCPC_VCO_LO];
            bw_d         = i_nvm_load_loop_bw[`SCPC_BW_BIT];
            prog_count_d = i_nvm_load_count; // [R9]
        end else if (store_d) begin
            prog_count_d = store_data_d; // [R7]
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                `SCPC_ADDR_CAL_WAIT: rdata_d = {4'h0, clsd_code_q, vco_code_q};
                `SCPC_ADDR_LOOP_BW:  rdata_d = {7'h00, bw_q};
                `SCPC_ADDR_PROG_CNT: rdata_d = prog_count_q;
                default:             rdata_d = `SCPC_RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            clsd_code_q  <= `SCPC_CLSD_RST; // [R3]
            vco_code_q   <= `SCPC_VCO_RST; // [R4]
            bw_q         <= `SCPC_BW_RST;
            prog_count_q <= `SCPC_CNT_RST; // [R11]
            rdata_q      <= `SCPC_RD_ZERO;
        end else begin
            clsd_code_q  <= clsd_code_d;
            vco_code_q   <= vco_code_d;
            bw_q         <= bw_d;
            prog_count_q <= prog_count_d;
            rdata_q      <= rdata_d;
        end
    end

    // A commit request in the completing cycle stays pending, so it is not lost.
    always_comb begin
        nvm_d          = nvm_q;
        boot_d         = boot_q;
        commit_d       = (commit_q && !load_now) || i_commit_req; // [R13]
        load_req_d     = 1'b0;
        store_d        = 1'b0;
        store_data_d   = store_data_q;
        prog_tmr_start = 1'b0;
        case (nvm_q)
            NVM_IDLE: begin
                if (boot_q || commit_q) begin
                    boot_d     = 1'b0;
                    load_req_d = 1'b1; // [R9]
                    nvm_d      = NVM_LOAD;
                end else if (i_prog_start) begin
                    prog_tmr_start = 1'b1; // [R12]
                    nvm_d          = NVM_PROG;
                end
            end
            NVM_LOAD: begin
                if (i_nvm_load_valid) begin
                    nvm_d = NVM_IDLE;
                end
            end
            NVM_PROG: begin
                if (prog_tmr_done) begin
                    store_d      = 1'b1; // [R8]
                    store_data_d = sat_inc(prog_count_q); // [R7]
                    load_req_d   = 1'b1; // [R9]
                    nvm_d        = NVM_LOAD;
                end
            end
            default: nvm_d = NVM_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            nvm_q        <= NVM_IDLE;
            boot_q       <= 1'b1;
            commit_q     <= 1'b0;
            load_req_q   <= 1'b0;
            store_q      <= 1'b0;
            store_data_q <= `SCPC_CNT_RST;
        end else begin
            nvm_q        <= nvm_d;
            boot_q       <= boot_d;
            commit_q     <= commit_d;
            load_req_q   <= load_req_d;
            store_q      <= store_d;
            store_data_q <= store_data_d;
        end
    end

    scpc_wait_timer #(.W(TMR_W)) u_prog_timer (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (prog_tmr_start),
        .i_cycles  (TMR_W'(PROG_CYC)),
        .o_busy    (),
        .o_done    (prog_tmr_done)
    );

    // Both lengths are captured at start so a mid-run rewrite cannot skew it.
    always_comb begin
        cal_d          = cal_q;
        vco_len_d      = vco_len_q;
        clsd_len_d     = clsd_len_q;
        cal_done_d     = 1'b0;
        cal_tmr_start  = 1'b0;
        cal_tmr_cycles = vco_len_q;
        case (cal_q)
            CAL_IDLE: begin
                if (i_cal_start) begin
                    vco_len_d = pick_wait(vco_code_q, VCO0_CYC, VCO1_CYC,
                                          VCO2_CYC, VCO3_CYC); // [R4]
                    clsd_len_d = pick_wait(clsd_code_q, CLSD0_CYC, CLSD1_CYC,
                                           CLSD2_CYC, CLSD3_CYC); // [R1]
                    cal_tmr_cycles = vco_len_d;
                    cal_tmr_start  = 1'b1; // [R14]
                    cal_d          = CAL_VCO;
                end
            end
            CAL_VCO: begin
                if (cal_tmr_done) begin
                    cal_tmr_cycles = clsd_len_q;
                    cal_tmr_start  = 1'b1; // [R14]
                    cal_d          = CAL_CLSD;
                end
            end
            CAL_CLSD: begin
                if (cal_tmr_done) begin
                    cal_done_d = 1'b1;
                    cal_d      = CAL_IDLE;
                end
            end
            default: cal_d = CAL_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cal_q      <= CAL_IDLE;
            vco_len_q  <= '0;
            clsd_len_q <= '0;
            cal_done_q <= 1'b0;
        end else begin
            cal_q      <= cal_d;
            vco_len_q  <= vco_len_d;
            clsd_len_q <= clsd_len_d;
            cal_done_q <= cal_done_d;
        end
    end

    scpc_wait_timer #(.W(TMR_W)) u_cal_timer (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (cal_tmr_start),
        .i_cycles  (cal_tmr_cycles),
        .o_busy    (),
        .o_done    (cal_tmr_done)
    );

    assign o_reg_rdata            = rdata_q;
    assign o_cal_busy             = (cal_q != CAL_IDLE);
    assign o_cal_done             = cal_done_q;
    assign o_narrow_bw            = bw_q; // [R6]
    assign o_commit_pending       = commit_q;
    assign o_nvm_busy             = (nvm_q == NVM_PROG);
    assign o_nvm_load_req         = load_req_q;
    assign o_nvm_count_store      = store_q;
    assign o_nvm_count_store_data = store_data_q;

    // Cycles spent in the current calibration phase, read only by assertions.
    logic [TMR_W-1:0] phase_cyc_q;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || cal_d != cal_q) begin
            phase_cyc_q <= '0;
        end else begin
            phase_cyc_q <= phase_cyc_q + TMR_W'(1);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    vco_phase_len_a: assert property (cal_q == CAL_VCO && cal_tmr_done |-> // [R4]
        phase_cyc_q == vco_len_q - TMR_W'(1) ##1 cal_q == CAL_CLSD)
        else $error("VCO wait phase has the wrong length");
    clsd_phase_len_a: assert property (cal_q == CAL_CLSD && cal_tmr_done |-> // [R1]
        phase_cyc_q == clsd_len_q - TMR_W'(1) ##1 (cal_q == CAL_IDLE && o_cal_done))
        else $error("Closed-loop wait phase has the wrong length");
    cal_order_a: assert property (cal_q == CAL_IDLE && i_cal_start |=> // [R14]
        cal_q == CAL_VCO [*2])
        else $error("Calibration did not open with the VCO wait");
    wait_reset_a: assert property (@(posedge i_clk) disable iff (1'b0) // [R3]
        i_sys_rst |=> (clsd_code_q == `SCPC_CLSD_RST && vco_code_q == `SCPC_VCO_RST))
        else $error("Wait codes have wrong reset values");
    count_reset_a: assert property (@(posedge i_clk) disable iff (1'b0) // [R11]
        i_sys_rst |=> prog_count_q == `SCPC_CNT_RST)
        else $error("Program count not zero after reset");
    count_ro_a: assert property (i_reg_wr && i_reg_addr == `SCPC_ADDR_PROG_CNT // [R11]
        && !load_now && !store_d |=> $stable(prog_count_q))
        else $error("Software write changed the program count");
    // The step is compared in nine bits, so a wrap from the top cannot pass for a step.
    count_sat_a: assert property (store_q |-> prog_count_q == store_data_q && // [R10]
        (prog_count_q == `SCPC_CNT_MAX ||
         {1'b0, prog_count_q} == {1'b0, $past(prog_count_q)} + 9'h001))
        else $error("Program count did not step or saturate");
    // Checked in the store cycle itself: the memory may answer the request at once.
    store_reload_a: assert property (store_q |-> o_nvm_load_req // [R9]
        && nvm_q == NVM_LOAD)
        else $error("Program cycle end did not request a reload");
    commit_clear_a: assert property (commit_q && load_now && !i_commit_req // [R13]
        |=> !commit_q)
        else $error("Commit bit did not self-clear");
    bw_write_a: assert property (i_reg_wr && i_reg_addr == `SCPC_ADDR_LOOP_BW // [R6]
        && !load_now |=> o_narrow_bw == $past(i_reg_wdata[`SCPC_BW_BIT]))
        else $error("Bandwidth select did not follow the write");

endmodule : scpc_top

// [src/scpc_wait_timer.sv]
/*
 * Down-counting wait timer: a start pulse loads a cycle count and the done
 * pulse rises exactly that many cycles later.
 * Assumes the count is at least one and a start only when not busy or in its done cycle.
 */
`timescale 1ns/1ps

module scpc_wait_timer #(
    parameter int W = 27
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_start,
    input  wire logic [W-1:0] i_cycles,
    output logic              o_busy,
    output logic              o_done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (i_start) begin
            cnt_d = i_cycles;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_busy = (cnt_q != '0);
    assign o_done = (cnt_q == W'(1));

endmodule : scpc_wait_timer

// [verif/scpc_top_tb.sv]
/*
 * Self-checking testbench for the calibration wait and program-cycle counter bank.
 * Assumes the bench plays both the register master and the nonvolatile memory.
 */
`timescale 1ns/1ps
`include "scpc_cfg.svh"

`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            $display("[ERR] %s expected %h seen %h", what, exp, got); \
            bad_count++; \
        end \
    end

module scpc_top_tb;
    // Short wait counts keep the run brief; each code gets a distinct length.
    localparam int unsigned VC [4] = '{3, 5, 7, 9};
    localparam int unsigned CC [4] = '{4, 6, 8, 11};
    localparam int unsigned PROG   = 20;

    logic       i_clk;
    logic       i_sys_rst;
    logic       i_reg_wr;
    logic       i_reg_rd;
    logic [7:0] i_reg_addr;
    logic [7:0] i_reg_wdata;
    logic [7:0] o_reg_rdata;
    logic       i_cal_start;
    logic       o_cal_busy;
    logic       o_cal_done;
    logic       o_narrow_bw;
    logic       i_commit_req;
    logic       o_commit_pending;
    logic       i_prog_start;
    logic       o_nvm_busy;
    logic       o_nvm_load_req;
    logic       i_nvm_load_valid;
    logic [7:0] i_nvm_load_cal_wait;
    logic [7:0] i_nvm_load_loop_bw;
    logic [7:0] i_nvm_load_count;
    logic       o_nvm_count_store;
    logic [7:0] o_nvm_count_store_data;
    int         bad_count;
    int         n_compared;

    scpc_top #(
        .CLSD0_CYC(CC[0]), .CLSD1_CYC(CC[1]), .CLSD2_CYC(CC[2]), .CLSD3_CYC(CC[3]),
        .VCO0_CYC (VC[0]), .VCO1_CYC (VC[1]), .VCO2_CYC (VC[2]), .VCO3_CYC (VC[3]),
        .PROG_CYC (PROG)
    ) dut (
        .i_clk                 (i_clk),
        .i_sys_rst             (i_sys_rst),
        .i_reg_wr              (i_reg_wr),
        .i_reg_rd              (i_reg_rd),
        .i_reg_addr            (i_reg_addr),
        .i_reg_wdata           (i_reg_wdata),
        .o_reg_rdata           (o_reg_rdata),
        .i_cal_start           (i_cal_start),
        .o_cal_busy            (o_cal_busy),
        .o_cal_done            (o_cal_done),
        .o_narrow_bw           (o_narrow_bw),
        .i_commit_req          (i_commit_req),
        .o_commit_pending      (o_commit_pending),
        .i_prog_start          (i_prog_start),
        .o_nvm_busy            (o_nvm_busy),
        .o_nvm_load_req        (o_nvm_load_req),
        .i_nvm_load_valid      (i_nvm_load_valid),
        .i_nvm_load_cal_wait   (i_nvm_load_cal_wait),
        .i_nvm_load_loop_bw    (i_nvm_load_loop_bw),
        .i_nvm_load_count      (i_nvm_load_count),
        .o_nvm_count_store     (o_nvm_count_store),
        .o_nvm_count_store_data(o_nvm_count_store_data)
    );

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask : reg_wr

    task automatic reg_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        `CHK(what, exp, o_reg_rdata)
    endtask : reg_chk

    // The memory answers one cycle; afterwards its data lines show a changed
    // pattern so a design that samples late cannot pass by luck.
    task automatic mem_answer(input logic [7:0] cw, input logic [7:0] bw, input logic [7:0] cnt);
        @(negedge i_clk);
        i_nvm_load_valid = 1'b1;
        i_nvm_load_cal_wait = cw;
        i_nvm_load_loop_bw = bw;
        i_nvm_load_count = cnt;
        @(negedge i_clk);
        i_nvm_load_valid = 1'b0;
        i_nvm_load_cal_wait = ~cw;
        i_nvm_load_loop_bw = ~bw;
        i_nvm_load_count = ~cnt;
    endtask : mem_answer

    task automatic t_boot();
        int k;
        k = 0;
        while (o_nvm_load_req !== 1'b1 && k < 20) begin
            @(negedge i_clk);
            k++;
        end
        `CHK("boot load request", 1'b1, o_nvm_load_req)
        reg_chk("wait control reset", `SCPC_ADDR_CAL_WAIT, 8'h01);
        reg_chk("bandwidth reset", `SCPC_ADDR_LOOP_BW, 8'h00);
        reg_chk("count reset", `SCPC_ADDR_PROG_CNT, 8'h00);
        `CHK("narrow bw reset", 1'b0, o_narrow_bw)
        mem_answer(8'hFD, 8'hFF, 8'h05);
        reg_chk("wait control loaded", `SCPC_ADDR_CAL_WAIT, 8'h0D);
        reg_chk("bandwidth loaded", `SCPC_ADDR_LOOP_BW, 8'h01);
        reg_chk("count loaded", `SCPC_ADDR_PROG_CNT, 8'h05);
        `CHK("narrow bw loaded", 1'b1, o_narrow_bw)
        $display("test boot done");
    endtask : t_boot

    task automatic t_regs();
        reg_wr(`SCPC_ADDR_CAL_WAIT, 8'hF6);
        reg_chk("wait control rw", `SCPC_ADDR_CAL_WAIT, 8'h06);
        reg_wr(`SCPC_ADDR_LOOP_BW, 8'hFE);
        reg_chk("bandwidth rw", `SCPC_ADDR_LOOP_BW, 8'h00);
        `CHK("narrow bw cleared", 1'b0, o_narrow_bw)
        reg_wr(`SCPC_ADDR_PROG_CNT, 8'hAA);
        reg_chk("count write ignored", `SCPC_ADDR_PROG_CNT, 8'h05);
        reg_chk("unmapped read", 8'h87, 8'h00);
        $display("test registers done");
    endtask : t_regs

    // A second start at cycle 2 must be ignored, or the done pulse comes late.
    task automatic cal_run(input int v, input int c);
        int k;
        reg_wr(`SCPC_ADDR_CAL_WAIT, {4'h0, 2'(c), 2'(v)});
        @(negedge i_clk);
        i_cal_start = 1'b1;
        @(negedge i_clk);
        i_cal_start = 1'b0;
        k = 1;
        `CHK("calibration busy", 1'b1, o_cal_busy)
        while (o_cal_done !== 1'b1 && k < 100) begin
            @(negedge i_clk);
            k++;
            i_cal_start = (k == 2);
        end
        i_cal_start = 1'b0;
        `CHK("calibration length", VC[v] + CC[c] + 1, k)
        @(negedge i_clk);
        `CHK("calibration idle", 1'b0, o_cal_busy)
        `CHK("calibration done pulse", 1'b0, o_cal_done)
    endtask : cal_run

    task automatic t_cal();
        for (int i = 0; i < 4; i++) begin
            cal_run(i, 3 - i);
        end
        $display("test calibration done");
    endtask : t_cal

    task automatic t_prog(input logic [7:0] exp);
        int k;
        @(negedge i_clk);
        i_prog_start = 1'b1;
        @(negedge i_clk);
        i_prog_start = 1'b0;
        k = 1;
        `CHK("program busy", 1'b1, o_nvm_busy)
        while (o_nvm_count_store !== 1'b1 && k < 200) begin
            @(negedge i_clk);
            k++;
        end
        `CHK("program length", PROG + 1, k)
        `CHK("program busy end", 1'b0, o_nvm_busy)
        `CHK("stored count", exp, o_nvm_count_store_data)
        `CHK("reload after program", 1'b1, o_nvm_load_req)
        mem_answer(8'h06, 8'h00, exp);
        reg_chk("count after program", `SCPC_ADDR_PROG_CNT, exp);
        $display("test program done");
    endtask : t_prog

    task automatic t_commit(input logic [7:0] cnt);
        @(negedge i_clk);
        i_commit_req = 1'b1;
        @(negedge i_clk);
        i_commit_req = 1'b0;
        `CHK("commit pending", 1'b1, o_commit_pending)
        @(negedge i_clk);
        `CHK("commit load request", 1'b1, o_nvm_load_req)
        mem_answer(8'h05, 8'h00, cnt);
        `CHK("commit cleared", 1'b0, o_commit_pending)
        reg_chk("count after commit", `SCPC_ADDR_PROG_CNT, cnt);
        $display("test commit done");
    endtask : t_commit

    // A mid-run reset must drop the changed codes and the full count before the reload.
    task automatic t_rerst();
        @(negedge i_clk);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_boot();
        $display("test mid-run reset done");
    endtask : t_rerst

    initial begin
        #40000;
        $display("[ERR] watchdog expected finish seen hang");
        bad_count++;
        test_done();
    end

    initial begin
        bad_count = 0;
        n_compared = 0;
        i_sys_rst = 1'b1;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_cal_start = 1'b0;
        i_commit_req = 1'b0;
        i_prog_start = 1'b0;
        i_nvm_load_valid = 1'b0;
        i_nvm_load_cal_wait = 8'h00;
        i_nvm_load_loop_bw = 8'h00;
        i_nvm_load_count = 8'h00;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_boot();
        t_regs();
        t_cal();
        t_prog(8'h06);
        t_commit(8'hFE);
        t_prog(8'hFF);
        t_prog(8'hFF);
        t_rerst();
        test_done();
    end
endmodule : scpc_top_tb
